// file: src/efc_ctrl.sv
// Purpose: flash command controller, one or two instances, AXI4-Lite
// Assumes: flash array timing is modelled only by the operation timer
// Notes: a keyed command written while busy is ignored; a bad key still flags an error
`timescale 1ns/1ps
`default_nettype none
// Function
// - Mode bits 0,2,3 enable three interrupts
// - Mode bit 7 skips erase before programming
// - Wait states set read/write access cycles
// - Command acts only with key 0x5A
// - Four-bit command code decode
// - Code zero is no operation, no error
// - Reserved code sets programming error
// - Write-then-lock locks region after programming
// - Erase all refused if any region locked
// - Page field meaning depends on command
// - Status bit 0 shows ready
// - Lock error sticky, cleared by status read
// - Status bit 3 flags bad key/code
// - Status bit 4 shows security bit
// - Status bits 8-10 show NVM bits
// - Status bits 16-31 show region locks
// - Small variant lacks lock regions 8-15
// - Instances at 0x60-0x68 and 0x70-0x78
// - Second instance lacks security and NVM
// - Valid command clears ready until done
// - Ready raises interrupt when enabled
module efc_ctrl
#(
   parameter bit SECOND_PRESENT = 1'b1,
   parameter int LOCK_REGIONS = 16,
   parameter logic [15:0] ERASE_UNITS = 16'h0004,
   parameter logic [15:0] PROG_UNITS = 16'h0004,
   parameter logic [15:0] LOCK_UNITS = 16'h0002,
   parameter logic [15:0] ERASE_ALL_UNITS = 16'h0008,
   parameter logic [15:0] NVM_UNITS = 16'h0002
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_first,
   output logic irq_second,
   output logic [2:0] read_cycles_first,
   output logic [2:0] read_cycles_second
);
   import efc_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [1:0][31:0] mode;
      logic [1:0] active;
      logic [1:0] start;
      logic [1:0][15:0] units;
      logic [1:0][3:0] op;
      logic [1:0][9:0] page;
      logic [1:0] lock_err;
      logic [1:0] prog_err;
      logic [1:0] security;
      logic [1:0][GP_BITS-1:0] gpnvm;
      logic [1:0][15:0] locks;
   } efc_state_t;

   efc_state_t state_reg;
   efc_state_t state_next;
   logic [1:0] tmr_busy;
   logic [1:0] tmr_done;
   logic [1:0] inst_on;
   logic [1:0] cmd_wr;
   logic [1:0] mode_wr;
   logic [1:0] stat_rd;
   logic [1:0][31:0] status;
   logic [15:0] lock_mask;
   logic [31:0] strb_mask;
   logic wr_fire;
   logic rd_fire;
   logic wr_mapped;
   logic rd_mapped;

   // =========================================================
   // Helpers
   function automatic logic [2:0] write_cycles(input logic [1:0] ws);
      write_cycles = (ws == 2'h3) ? 3'h4 : {1'b0, ws} + 3'h2;
   endfunction

   function automatic logic [1:0] wait_field(input logic [31:0] m);
      wait_field = m[WS_LSB +: 2];
   endfunction

   assign inst_on = {SECOND_PRESENT, 1'b1};
   // Small variant: regions numbered LOCK_REGIONS and up are absent
   assign lock_mask = 16'hFFFF >> (16 - LOCK_REGIONS);

   // =========================================================
   // Status words
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         status[i] = '0;
         status[i][ST_READY_BIT] = !state_reg.active[i];
         status[i][ST_LOCK_ERR_BIT] = state_reg.lock_err[i];
         status[i][ST_PROG_ERR_BIT] = state_reg.prog_err[i];
         if (i == 0)
         begin
            status[i][ST_SECURE_BIT] = state_reg.security[i];
            status[i][ST_GP_LSB +: GP_BITS] = state_reg.gpnvm[i];
         end
         status[i][ST_LOCK_LSB +: 16] = state_reg.locks[i] & lock_mask;
      end
   end

   // =========================================================
   // Bus decode, one write and one read in flight
   assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
   assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
   assign s_axi_arready = !state_reg.rvalid;
   assign wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         strb_mask[i*8 +: 8] = {8{state_reg.wstrb[i]}};
      end
      mode_wr[0] = wr_fire && state_reg.awaddr == FLASH_MODE_FIRST;
      mode_wr[1] = wr_fire && state_reg.awaddr == FLASH_MODE_SECOND
         && SECOND_PRESENT;
      // A command needs all four lanes so the key lands with the code
      cmd_wr[0] = wr_fire && state_reg.awaddr == FLASH_COMMAND_FIRST
         && state_reg.wstrb == 4'hF;
      cmd_wr[1] = wr_fire && state_reg.awaddr == FLASH_COMMAND_SECOND
         && state_reg.wstrb == 4'hF && SECOND_PRESENT;
      wr_mapped = state_reg.awaddr == FLASH_MODE_FIRST
         || state_reg.awaddr == FLASH_COMMAND_FIRST
         || state_reg.awaddr == FLASH_STATUS_FIRST
         || state_reg.awaddr == RESERVED_FIRST
         || (SECOND_PRESENT && state_reg.awaddr[7:4] == FLASH_MODE_SECOND[7:4]
            && state_reg.awaddr[1:0] == 2'h0);
      stat_rd[0] = rd_fire && s_axi_araddr == FLASH_STATUS_FIRST;
      stat_rd[1] = rd_fire && s_axi_araddr == FLASH_STATUS_SECOND
         && SECOND_PRESENT;
      rd_mapped = (s_axi_araddr[7:4] == FLASH_MODE_FIRST[7:4]
         || (SECOND_PRESENT && s_axi_araddr[7:4] == FLASH_MODE_SECOND[7:4]))
         && s_axi_araddr[1:0] == 2'h0;
   end

   // =========================================================
   // Next state
   always_comb
   begin
      logic [3:0] code;
      logic [9:0] pg;
      logic [3:0] rg;
      code = state_reg.wdata[3:0];
      pg = state_reg.wdata[PAGE_LSB +: 10];
      rg = '0;
      state_next = state_reg;
      state_next.start = '0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         state_next.aw_got = 1'b1;
         state_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         state_next.w_got = 1'b1;
         state_next.wdata = s_axi_wdata;
         state_next.wstrb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         state_next.aw_got = 1'b0;
         state_next.w_got = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (state_reg.bvalid && s_axi_bready)
         state_next.bvalid = 1'b0;
      if (rd_fire)
      begin
         state_next.rvalid = 1'b1;
         state_next.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            FLASH_MODE_FIRST: state_next.rdata = state_reg.mode[0];
            FLASH_STATUS_FIRST: state_next.rdata = status[0];
            FLASH_MODE_SECOND: state_next.rdata = state_reg.mode[1];
            FLASH_STATUS_SECOND: state_next.rdata = status[1];
            default: state_next.rdata = '0;
         endcase
      end
      if (state_reg.rvalid && s_axi_rready)
         state_next.rvalid = 1'b0;

      for (int i = 0; i < 2; i++)
      begin
         // Clear on read first so a same-cycle event below wins
         if (stat_rd[i])
         begin
            state_next.lock_err[i] = 1'b0;
            state_next.prog_err[i] = 1'b0;
         end
         if (mode_wr[i])
            state_next.mode[i] = (state_reg.mode[i] & ~strb_mask)
               | (state_reg.wdata & strb_mask & MODE_MASK);
         // Operation finished
         if (tmr_done[i])
         begin
            rg = state_reg.page[i][REGION_LSB +: 4];
            state_next.active[i] = 1'b0;
            case (state_reg.op[i])
               CMD_WRITE_PAGE_LOCK:
               begin
                  state_next.active[i] = 1'b1;
                  state_next.op[i] = CMD_SET_LOCK;
                  state_next.units[i] = LOCK_UNITS;
                  state_next.start[i] = 1'b1;
               end
               CMD_SET_LOCK: state_next.locks[i][rg] = lock_mask[rg];
               CMD_CLEAR_LOCK: state_next.locks[i][rg] = 1'b0;
               CMD_SET_GP_BIT:
                  if (i == 0 && state_reg.page[i] < GP_COUNT)
                     state_next.gpnvm[i][state_reg.page[i][1:0]] = 1'b1;
               CMD_CLEAR_GP_BIT:
                  if (i == 0 && state_reg.page[i] < GP_COUNT)
                     state_next.gpnvm[i][state_reg.page[i][1:0]] = 1'b0;
               CMD_SET_SECURE:
                  if (i == 0)
                     state_next.security[i] = 1'b1;
               default: state_next.op[i] = state_reg.op[i];
            endcase
         end
         // Command write
         if (cmd_wr[i])
         begin
            rg = pg[REGION_LSB +: 4];
            if (state_reg.wdata[KEY_LSB +: 8] != CMD_KEY)
               state_next.prog_err[i] = 1'b1;
            else if (!state_reg.active[i])
            begin
               case (code)
                  CMD_NOP: state_next.op[i] = state_reg.op[i];
                  CMD_WRITE_PAGE, CMD_WRITE_PAGE_LOCK:
                     if (state_reg.locks[i][rg] && lock_mask[rg])
                        state_next.lock_err[i] = 1'b1;
                     else
                     begin
                        state_next.start[i] = 1'b1;
                        state_next.units[i] =
                           state_reg.mode[i][SKIP_ERASE_BIT] ? PROG_UNITS
                           : PROG_UNITS + ERASE_UNITS;
                     end
                  CMD_SET_LOCK, CMD_CLEAR_LOCK:
                  begin
                     state_next.start[i] = 1'b1;
                     state_next.units[i] = LOCK_UNITS;
                  end
                  CMD_ERASE_ALL:
                     if (|(state_reg.locks[i] & lock_mask))
                        state_next.lock_err[i] = 1'b1;
                     else
                     begin
                        state_next.start[i] = 1'b1;
                        state_next.units[i] = ERASE_ALL_UNITS;
                     end
                  CMD_SET_GP_BIT, CMD_CLEAR_GP_BIT, CMD_SET_SECURE:
                  begin
                     state_next.start[i] = 1'b1;
                     state_next.units[i] = NVM_UNITS;
                  end
                  default: state_next.prog_err[i] = 1'b1;
               endcase
               if (state_next.start[i])
               begin
                  state_next.active[i] = 1'b1;
                  state_next.op[i] = code;
                  state_next.page[i] = pg;
               end
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= '0;
         state_reg.mode <= {MODE_RESET, MODE_RESET};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // =========================================================
   // Operation timers
   for (genvar g = 0; g < 2; g++)
   begin : g_tmr
      efc_timer u_timer
      (
         .aclk(aclk),
         .aresetn(aresetn && inst_on[g]),
         .start(state_reg.start[g]),
         .units(state_reg.units[g]),
         .unit_cycles(state_reg.mode[g][MCYC_LSB +: 8]),
         .extra_cycles(write_cycles(wait_field(state_reg.mode[g]))),
         .busy(tmr_busy[g]),
         .done(tmr_done[g])
      );
   end

   // =========================================================
   // Outputs
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rresp = state_reg.rresp;
   assign s_axi_rdata = state_reg.rdata;
   assign irq_first = |(status[0][3:0] & state_reg.mode[0][3:0]);
   assign irq_second = |(status[1][3:0] & state_reg.mode[1][3:0])
      && SECOND_PRESENT;
   assign read_cycles_first = {1'b0, wait_field(state_reg.mode[0])}
      + 3'h1;
   assign read_cycles_second = {1'b0, wait_field(state_reg.mode[1])}
      + 3'h1;

   // =========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [3:0] code_of0;
   assign code_of0 = state_reg.wdata[3:0];

   sequence keyed_cmd0(logic [3:0] c);
      cmd_wr[0] && state_reg.wdata[KEY_LSB +: 8] == CMD_KEY
         && !state_reg.active[0] && code_of0 == c;
   endsequence

   bad_key_a: assert property (
      cmd_wr[0] && state_reg.wdata[KEY_LSB +: 8] != CMD_KEY
      && !state_reg.active[0] |=> state_reg.prog_err[0]
      && !state_reg.active[0] && !state_reg.start[0])
      else $error("bad key was not refused");
   nop_quiet_a: assert property (
      keyed_cmd0(CMD_NOP) and (!state_reg.prog_err[0])
      |=> !state_reg.prog_err[0] && !state_reg.active[0])
      else $error("no-op changed state");
   reserved_code_a: assert property (
      keyed_cmd0(4'h5) |=> state_reg.prog_err[0] && !state_reg.active[0])
      else $error("reserved code did not flag error");
   ready_drop_a: assert property (
      keyed_cmd0(CMD_SET_LOCK) |=> !status[0][ST_READY_BIT]
      ##1 tmr_busy[0])
      else $error("ready did not drop on command");
   erase_abort_a: assert property (
      keyed_cmd0(CMD_ERASE_ALL) and (|(state_reg.locks[0] & lock_mask))
      |=> state_reg.lock_err[0] && status[0][ST_READY_BIT]
      ##1 !tmr_busy[0])
      else $error("erase all ran with a locked region");
   lock_chain_a: assert property (
      tmr_done[0] && state_reg.op[0] == CMD_WRITE_PAGE_LOCK
      |=> state_reg.op[0] == CMD_SET_LOCK && state_reg.active[0]
      ##1 tmr_busy[0])
      else $error("lock did not follow page write");
   lock_err_clear_a: assert property (
      stat_rd[0] && !cmd_wr[0] |=> !state_reg.lock_err[0])
      else $error("status read did not clear lock error");
   ready_irq_a: assert property (
      $rose(status[0][ST_READY_BIT]) && state_reg.mode[0][READY_IE_BIT]
      |-> irq_first)
      else $error("ready interrupt missing");
   second_bare_a: assert property (
      stat_rd[1] |=> s_axi_rdata[ST_SECURE_BIT] == 1'b0
      && s_axi_rdata[ST_GP_LSB +: GP_BITS] == '0)
      else $error("second instance shows security or nvm");
   skip_erase_a: assert property (
      keyed_cmd0(CMD_WRITE_PAGE) and (state_reg.mode[0][SKIP_ERASE_BIT])
      and (!state_reg.locks[0][state_reg.wdata[PAGE_LSB+REGION_LSB +: 4]])
      |=> state_reg.units[0] == PROG_UNITS)
      else $error("erase not skipped");
endmodule
`default_nettype wire

// file: src/efc_pkg.sv
// Purpose: shared constants of the embedded flash command controller
// Assumes: AXI4-Lite byte addresses inside the memory controller window
// Notes: offsets are the low byte of the address
package efc_pkg;
   // =========================================================
   // Register map
   localparam logic [7:0] FLASH_MODE_FIRST = 8'h60;
   localparam logic [7:0] FLASH_COMMAND_FIRST = 8'h64;
   localparam logic [7:0] FLASH_STATUS_FIRST = 8'h68;
   localparam logic [7:0] FLASH_MODE_SECOND = 8'h70;
   localparam logic [7:0] FLASH_COMMAND_SECOND = 8'h74;
   localparam logic [7:0] FLASH_STATUS_SECOND = 8'h78;
   localparam logic [7:0] RESERVED_FIRST = 8'h6C;
   localparam logic [7:0] RESERVED_SECOND = 8'h7C;
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODE_MASK = 32'h00FF_038D;
   // =========================================================
   // Mode fields
   localparam int READY_IE_BIT = 0;
   localparam int LOCK_IE_BIT = 2;
   localparam int PROG_IE_BIT = 3;
   localparam int SKIP_ERASE_BIT = 7;
   localparam int WS_LSB = 8;
   localparam int MCYC_LSB = 16;
   // =========================================================
   // Command fields
   localparam int KEY_LSB = 24;
   localparam int PAGE_LSB = 8;
   localparam logic [7:0] CMD_KEY = 8'h5A;
   localparam int REGION_LSB = 6;
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WRITE_PAGE = 4'h1;
   localparam logic [3:0] CMD_SET_LOCK = 4'h2;
   localparam logic [3:0] CMD_WRITE_PAGE_LOCK = 4'h3;
   localparam logic [3:0] CMD_CLEAR_LOCK = 4'h4;
   localparam logic [3:0] CMD_ERASE_ALL = 4'h8;
   localparam logic [3:0] CMD_SET_GP_BIT = 4'hB;
   localparam logic [3:0] CMD_CLEAR_GP_BIT = 4'hD;
   localparam logic [3:0] CMD_SET_SECURE = 4'hF;
   // =========================================================
   // Status fields
   localparam int ST_READY_BIT = 0;
   localparam int ST_LOCK_ERR_BIT = 2;
   localparam int ST_PROG_ERR_BIT = 3;
   localparam int ST_SECURE_BIT = 4;
   localparam int ST_GP_LSB = 8;
   localparam int ST_LOCK_LSB = 16;
   localparam int GP_BITS = 3;
   localparam logic [9:0] GP_COUNT = 10'h003;
   // =========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: src/efc_timer.sv
// Purpose: operation timer, counts units of microsecond_cycles clocks
// Assumes: start only while idle
// Notes: done is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
`default_nettype none
module efc_timer
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [15:0] units,
   input wire logic [7:0] unit_cycles,
   input wire logic [2:0] extra_cycles,
   output logic busy,
   output logic done
);
   import efc_pkg::*;

   typedef struct packed {
      logic busy;
      logic done;
      logic [15:0] ucnt;
      logic [8:0] cyc;
   } efc_tmr_t;

   efc_tmr_t state_reg;
   efc_tmr_t state_next;
   logic [8:0] tick;

   // A zero count is legal only for very slow clocks; treat it as one
   always_comb
   begin
      tick = (unit_cycles == 8'h00) ? 9'h001 : {1'b0, unit_cycles};
      state_next = state_reg;
      state_next.done = 1'b0;
      if (start)
      begin
         state_next.busy = 1'b1;
         state_next.ucnt = (units == 16'h0000) ? 16'h0001 : units;
         state_next.cyc = tick + {6'h00, extra_cycles};
      end
      else if (state_reg.busy)
      begin
         if (state_reg.cyc <= 9'h001)
         begin
            if (state_reg.ucnt == 16'h0001)
            begin
               state_next.busy = 1'b0;
               state_next.done = 1'b1;
            end
            else
            begin
               state_next.ucnt = state_reg.ucnt - 16'h0001;
               state_next.cyc = tick;
            end
         end
         else
         begin
            state_next.cyc = state_reg.cyc - 9'h001;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign busy = state_reg.busy;
   assign done = state_reg.done;

   timer_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_reg.busy && state_reg.cyc <= 9'h001 && state_reg.ucnt == 16'h0001
      |=> done && !busy)
      else $error("timer did not finish on last unit");
endmodule
`default_nettype wire

// file: verification/efc_axi_master.sv
// Purpose: AXI4-Lite master standing in for software
// Assumes: one write and one read at most under way
// Notes: handshakes judged on the falling edge before the taking edge
`timescale 1ns/1ps
`default_nettype none
module efc_axi_master
(
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial
   begin
      awaddr = 8'h00;
      wdata = 32'h0000_0000;
      araddr = 8'h00;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
   end
   // =========================================================
   // Write: both channels offered at once, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ga, gw, gb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ga = awvalid && awready;
         gw = wvalid && wready;
         gb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ga)
            awvalid <= 1'b0;
         if (gw)
            wvalid <= 1'b0;
      end
      while (!gb);
      bready <= 1'b0;
   endtask
   // =========================================================
   // Read
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic ga, gr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ga = arvalid && arready;
         gr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ga)
            arvalid <= 1'b0;
      end
      while (!gr);
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verification/embedded_flash_command_controller_tb.sv
// Purpose: self-checking bench of the flash command controller
// Assumes: default unit counts, microsecond_cycles set to 8
// Notes: status reads clear error flags, so order of reads matters
`timescale 1ns/1ps
`default_nettype none
module embedded_flash_command_controller_tb;
   import efc_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq_first, irq_second;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, r;
   logic [2:0] rc1, rc2;
   int fail_count = 0;
   int comparisons = 0;
   efc_ctrl i_efc_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_first(irq_first), .irq_second(irq_second),
      .read_cycles_first(rc1), .read_cycles_second(rc2));
   efc_axi_master i_efc_axi_master (.aclk(aclk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   // =========================================================
   // Helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e,
                      input string m);
      comparisons++;
      if (s !== e)
      begin
         fail_count++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      i_efc_axi_master.wr(a, d, r);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      i_efc_axi_master.rd(a, v, r);
   endtask
   // Bounded poll; v holds the last status seen
   task automatic wait_rdy(input logic [7:0] a);
      int n;
      n = 0;
      do
      begin
         rd_reg(a);
         n++;
      end
      while (v[ST_READY_BIT] !== 1'b1 && n < 300);
   endtask
   task automatic complete_run();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // =========================================================
   // Scenarios
   task automatic t_reg();
      rd_reg(FLASH_MODE_FIRST);
      chk(v, MODE_RESET, "mode reset");
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0001, "status reset");
      rd_reg(8'h80);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
      wr_reg(8'h80, 32'h0000_0000);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
      for (int w = 0; w < 4; w++)
      begin
         // Eight cycles per microsecond, never zero
         wr_reg(FLASH_MODE_FIRST, 32'h0008_0000 | (32'(w) << WS_LSB));
         wr_reg(FLASH_MODE_SECOND, 32'h0008_0000 | (32'(w) << WS_LSB));
         chk({29'h0, rc1}, 32'(w + 1), "read cycles 1");
         chk({29'h0, rc2}, 32'(w + 1), "read cycles 2");
      end
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "mode write okay");
      rd_reg(FLASH_MODE_SECOND);
      chk(v, 32'h0008_0300, "mode readback");
      $display("test reg done");
   endtask
   task automatic t_err();
      wr_reg(FLASH_MODE_FIRST, 32'h0008_0008);
      wr_reg(FLASH_COMMAND_FIRST, 32'hA500_0001);
      chk({31'h0, irq_first}, 32'h1, "error irq");
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0009, "bad key");
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0001, "cleared by read");
      chk({31'h0, irq_first}, 32'h0, "irq gone");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_0005);
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0009, "reserved code");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_0000);
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0001, "no operation");
      $display("test err done");
   endtask
   task automatic t_lock();
      wr_reg(FLASH_MODE_FIRST, 32'h0008_0001);
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_4002);
      chk({31'h0, irq_first}, 32'h0, "busy no irq");
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0002_0001, "region 1 locked");
      chk({31'h0, irq_first}, 32'h1, "ready irq");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_4101);
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0002_0005, "locked write");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_0008);
      rd_reg(FLASH_STATUS_FIRST);
      chk(v, 32'h0002_0005, "erase all refused");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_4004);
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0001, "unlocked");
      wr_reg(FLASH_MODE_FIRST, 32'h0008_0081);
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_0001);
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0000_0001, "write without erase");
      $display("test lock done");
   endtask
   task automatic t_nvm();
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_8003);
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0004_0001, "write then lock");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_010B);
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0004_0201, "nvm bit 1");
      wr_reg(FLASH_COMMAND_SECOND, 32'h5A00_010B);
      wait_rdy(FLASH_STATUS_SECOND);
      chk(v, 32'h0000_0001, "second no nvm");
      chk({31'h0, irq_second}, 32'h0, "second irq off");
      wr_reg(FLASH_MODE_SECOND, 32'h0008_0001);
      chk({31'h0, irq_second}, 32'h1, "second ready irq");
      wr_reg(FLASH_COMMAND_FIRST, 32'h5A00_000F);
      wait_rdy(FLASH_STATUS_FIRST);
      chk(v, 32'h0004_0211, "security");
      $display("test nvm done");
   endtask
   // =========================================================
   // Clock, watchdog, main sequence
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial
   begin
      #400000;
      fail_count++;
      complete_run();
   end
   initial
   begin
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reg();
      t_err();
      t_lock();
      t_nvm();
      complete_run();
   end
endmodule
`default_nettype wire
